// ===== vmr_top.sv
// Voltage-only measurement readout: capabilities word, result word,
// scan sequencer and new-result / overrun flagging with attention gating.
// Assumes the serial framing logic delivers decoded one-cycle read and write
// strobes on clk_i, and that the converter runs on the same clock.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Pulse a function event whenever a fresh result lands in the readout.
// - Set the new-result flag on store; reading the readout clears it.
// - Request attention for a new result only when attention enable is set.
// - Work correctly once sensors are enabled, with no setup first.
// - Capabilities register is read-only and always returns 0051h.
// - Capabilities bits 2:0 read 001, nine significant result bits.
// - Result bits sit left-aligned, unused lower field bits are zero.
// - Capabilities bit 3 reads 0, readout word is 16 bits.
// - Capabilities bits 8:4 report five voltage sensors.
// - Reserved bits of both registers always read zero.
// - Readout bits 4:2 give the sensor index of the held result.
// - Readout bits 15:7 hold the nine-bit result, MSB at bit 15.
// - Indices 0..4 are 2.5 V, 1.2 V, 3.3 V standby, 5 V, 12 V.
// - Nominal input on each sensor reads code 180h.
// - Codes span 00h to 1FFh; standby sensor never reads below 15Dh.
// - Unread result overwritten sets overrun; readout read clears both flags.
// - Convert only enabled sensors, ascending order, wrapping continuously.
module vmr_top
  import vmr_pkg::*;
#(
  parameter int unsigned N_SENSORS = 5
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // Register port from the serial framing logic
  input  wire logic                  reg_rd_i,
  input  wire logic                  reg_wr_i,
  input  wire logic [VMR_ADDR_W-1:0] reg_addr_i,
  input  wire logic [VMR_DATA_W-1:0] reg_wdata_i,
  output logic [VMR_DATA_W-1:0]      reg_rdata_o,
  output logic                       reg_rvalid_o,
  output logic                       reg_hit_o,
  // Control bits held by the control register outside this block
  input  wire logic [N_SENSORS-1:0]  sensor_enable_i,
  input  wire logic                  attention_enable_i,
  // Converter handshake
  output logic                       conv_start_o,
  output logic [VMR_IDX_W-1:0]       conv_index_o,
  input  wire logic                  conv_done_i,
  input  wire logic [VMR_CODE_W-1:0] conv_code_i,
  // Events and status toward the device status register and bus
  output logic                       function_event_o,
  output logic                       attention_req_o,
  output logic                       new_result_flag_o,
  output logic                       overrun_error_flag_o
);

  initial begin
    if (N_SENSORS != int'(VMR_CAPS_NSENS)) begin
      $error("N_SENSORS must match the reported sensor count");
    end
    // The code field must end at the top bit so the result stays left-aligned.
    if (VMR_CODE_LSB + VMR_CODE_W != VMR_DATA_W) begin
      $error("Result code must end at the top bit of the readout word");
    end
    if (VMR_IDX_LSB + VMR_IDX_W > VMR_CODE_LSB) begin
      $error("Sensor index field overlaps the result code");
    end
    if (N_SENSORS > (1 << VMR_IDX_W)) begin
      $error("Sensor index field too narrow for the sensor count");
    end
    // The word is assembled from fields, so a field edit must keep the fixed value.
    if ({VMR_CAPS_RSVD, VMR_CAPS_NSENS, VMR_CAPS_SIZE_16, VMR_CAPS_RES_9BIT} !=
        VMR_CAPS_VALUE) begin
      $error("Capabilities fields disagree with the fixed word");
    end
  end

  // Scan sequencer state.
  vmr_state_e           state_q, state_d;
  logic [VMR_IDX_W-1:0] scan_idx_q, scan_idx_d;
  logic [VMR_IDX_W-1:0] next_idx;
  logic                 any_enabled;
  logic                 first_q, first_d;

  // Result and flag state.
  vmr_result_s          held_q, held_d;
  logic                 new_flag_q, new_flag_d;
  logic                 ovr_flag_q, ovr_flag_d;
  logic                 event_q, event_d;
  logic                 attn_q, attn_d;

  // Read path state.
  logic [VMR_DATA_W-1:0] rdata_q, rdata_d;
  logic                  rvalid_q, rvalid_d;
  logic                  hit_q, hit_d;

  logic                  store;
  logic                  result_read;
  logic [VMR_CODE_W-1:0] code_fixed;
  logic [VMR_DATA_W-1:0] caps_word;
  logic [VMR_DATA_W-1:0] result_word;

  vmr_next_sensor #(
    .N_SENSORS (N_SENSORS)
  ) u_next (
    .cur_i    (scan_idx_q),
    .enable_i (sensor_enable_i),
    .next_o   (next_idx),
    .any_o    (any_enabled)
  );

  // The sequencer starts from reset with no preparation; the first pass
  // begins at the lowest enabled index rather than after index 0.
  always_comb begin
    state_d    = state_q;
    scan_idx_d = scan_idx_q;
    first_d    = first_q;
    case (state_q)
      VMR_ST_IDLE: begin
        if (any_enabled) begin
          if (first_q && sensor_enable_i[0]) begin
            scan_idx_d = VMR_IDX_2V5;
          end else begin
            scan_idx_d = next_idx;
          end
          first_d = 1'b0;
          state_d = VMR_ST_START;
        end
      end
      VMR_ST_START: begin
        state_d = VMR_ST_WAIT;
      end
      VMR_ST_WAIT: begin
        if (conv_done_i) begin
          state_d = VMR_ST_IDLE;
        end
      end
      default: begin
        state_d = VMR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q    <= VMR_ST_IDLE;
      scan_idx_q <= VMR_IDX_2V5;
      first_q    <= 1'b1;
    end else begin
      state_q    <= state_d;
      scan_idx_q <= scan_idx_d;
      first_q    <= first_d;
    end
  end

  assign conv_start_o = (state_q == VMR_ST_START);
  assign conv_index_o = scan_idx_q;

  // The standby input powers the device, so a reading below its floor
  // can only be converter noise; it is lifted to the floor.
  always_comb begin
    code_fixed = conv_code_i;
    if (scan_idx_q == VMR_IDX_SBY && conv_code_i < VMR_CODE_SBY_MIN) begin
      code_fixed = VMR_CODE_SBY_MIN;
    end
  end

  assign store       = (state_q == VMR_ST_WAIT) && conv_done_i;
  assign result_read = reg_rd_i && (reg_addr_i == VMR_RESULT_ADDR);

  // A store in the same cycle as a read wins: the read returns the old
  // word and the new word's flag stays set.
  always_comb begin
    held_d     = held_q;
    new_flag_d = new_flag_q;
    ovr_flag_d = ovr_flag_q;
    event_d    = 1'b0;
    attn_d     = 1'b0;
    if (result_read) begin
      new_flag_d = 1'b0;
      ovr_flag_d = 1'b0;
    end
    if (store) begin
      held_d.code  = code_fixed;
      held_d.index = scan_idx_q;
      new_flag_d   = 1'b1;
      event_d      = 1'b1;
      attn_d       = attention_enable_i;
      if (new_flag_q && !result_read) begin
        ovr_flag_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      held_q     <= '0;
      new_flag_q <= 1'b0;
      ovr_flag_q <= 1'b0;
      event_q    <= 1'b0;
      attn_q     <= 1'b0;
    end else begin
      held_q     <= held_d;
      new_flag_q <= new_flag_d;
      ovr_flag_q <= ovr_flag_d;
      event_q    <= event_d;
      attn_q     <= attn_d;
    end
  end

  assign function_event_o     = event_q;
  assign attention_req_o      = attn_q;
  assign new_result_flag_o    = new_flag_q;
  assign overrun_error_flag_o = ovr_flag_q;

  // Fixed capabilities word built from its fields.
  assign caps_word = {VMR_CAPS_RSVD,
                      VMR_CAPS_NSENS,
                      VMR_CAPS_SIZE_16,
                      VMR_CAPS_RES_9BIT};

  // Result word: code left-aligned at the top, index in 4:2, rest zero.
  always_comb begin
    result_word = '0;
    result_word[VMR_CODE_LSB +: VMR_CODE_W] = held_q.code;
    result_word[VMR_IDX_LSB +: VMR_IDX_W]   = held_q.index;
  end

  // Reads answer one cycle later from flops; writes are accepted and
  // dropped since both registers are read-only.
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    hit_d    = 1'b0;
    if (reg_rd_i) begin
      rvalid_d = 1'b1;
      case (reg_addr_i)
        VMR_CAPS_ADDR: begin
          rdata_d = caps_word;
          hit_d   = 1'b1;
        end
        VMR_RESULT_ADDR: begin
          rdata_d = result_word;
          hit_d   = 1'b1;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end else if (reg_wr_i) begin
      hit_d = (reg_addr_i == VMR_CAPS_ADDR) ||
              (reg_addr_i == VMR_RESULT_ADDR);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
      hit_q    <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      hit_q    <= hit_d;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign reg_hit_o    = hit_q;

  // Write data has no destination here.
  logic unused_wdata;
  assign unused_wdata = ^reg_wdata_i;

endmodule
`default_nettype wire

// ===== vmr_pkg.sv
// Constants, register map and carrier types of the voltage monitor readout.
// Assumes a decoded register port from the serial bus framing logic and a
// converter that answers one start request with one nine-bit result.
package vmr_pkg;

  // Register port addresses, six bits wide.
  localparam int unsigned VMR_ADDR_W = 6;
  localparam logic [5:0] VMR_CAPS_ADDR   = 6'h10;
  localparam logic [5:0] VMR_RESULT_ADDR = 6'h11;

  // Register and field layout.
  localparam int unsigned VMR_DATA_W = 16;
  localparam int unsigned VMR_CODE_W = 9;
  localparam int unsigned VMR_IDX_W  = 3;
  localparam int unsigned VMR_CODE_LSB = 7;
  localparam int unsigned VMR_IDX_LSB  = 2;

  // Capabilities fields.
  localparam logic [2:0] VMR_CAPS_RES_9BIT = 3'h1;
  localparam logic       VMR_CAPS_SIZE_16  = 1'h0;
  localparam logic [4:0] VMR_CAPS_NSENS    = 5'h05;
  localparam logic [6:0] VMR_CAPS_RSVD     = 7'h00;
  localparam logic [15:0] VMR_CAPS_VALUE   = 16'h0051;

  // Sensor index assignment.
  localparam logic [2:0] VMR_IDX_2V5 = 3'h0;
  localparam logic [2:0] VMR_IDX_1V2 = 3'h1;
  localparam logic [2:0] VMR_IDX_SBY = 3'h2;
  localparam logic [2:0] VMR_IDX_5V0 = 3'h3;
  localparam logic [2:0] VMR_IDX_12V = 3'h4;

  // Code range figures.
  localparam logic [8:0] VMR_CODE_NOMINAL = 9'h180;
  localparam logic [8:0] VMR_CODE_MIN     = 9'h000;
  localparam logic [8:0] VMR_CODE_MAX     = 9'h1ff;
  localparam logic [8:0] VMR_CODE_SBY_MIN = 9'h15d;

  // One held conversion result: the converter code plus the scanned sensor index.
  typedef struct packed {
    logic [8:0] code;
    logic [2:0] index;
  } vmr_result_s;

  // One register request from the bus framing logic.
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] addr;
    logic [15:0] wdata;
  } vmr_req_s;

  typedef enum logic [2:0] {
    VMR_ST_IDLE  = 3'b001,
    VMR_ST_START = 3'b010,
    VMR_ST_WAIT  = 3'b100
  } vmr_state_e;

endpackage

// ===== vmr_next_sensor.sv
// Picks the next enabled sensor above the current one, wrapping round.
// Assumes the enable vector is stable while it is being read.
`timescale 1ns/1ps
`default_nettype none
module vmr_next_sensor #(
  parameter int unsigned N_SENSORS = 5
) (
  // Scan position
  input  wire logic [2:0]           cur_i,
  input  wire logic [N_SENSORS-1:0] enable_i,
  // Choice
  output logic [2:0]                next_o,
  output logic                      any_o
);

  initial begin
    if (N_SENSORS < 1 || N_SENSORS > 8) begin
      $error("N_SENSORS must be 1 to 8");
    end
  end

  always_comb begin
    logic       found;
    int unsigned k;
    int unsigned cand;
    found  = 1'b0;
    next_o = cur_i;
    cand   = 0;
    k      = 0;
    // Walk from cur+1 upward, ending on cur itself, so a lone sensor repeats.
    for (k = 1; k <= N_SENSORS; k++) begin
      cand = (int'(cur_i) + k) % N_SENSORS;
      if (!found && enable_i[cand]) begin
        found  = 1'b1;
        next_o = cand[2:0];
      end
    end
    any_o = |enable_i;
  end

endmodule
`default_nettype wire

// ===== vmr_top_props.sv
// Checker for the readout register port, result flags and starts on enabled sensors only.
// Bound to vmr_top; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module vmr_top_props
  import vmr_pkg::*;
#(
  parameter int unsigned N_SENSORS = 5
) (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  // Register port
  input wire logic                  reg_rd_i,
  input wire logic                  reg_wr_i,
  input wire logic [VMR_ADDR_W-1:0] reg_addr_i,
  input wire logic [VMR_DATA_W-1:0] reg_rdata_o,
  input wire logic                  reg_rvalid_o,
  input wire logic                  reg_hit_o,
  // Scan, converter and status
  input wire logic [N_SENSORS-1:0]  sensor_enable_i,
  input wire logic                  attention_enable_i,
  input wire logic                  conv_start_o,
  input wire logic [VMR_IDX_W-1:0]  conv_index_o,
  input wire logic                  conv_done_i,
  input wire logic                  function_event_o,
  input wire logic                  attention_req_o,
  input wire logic                  new_result_flag_o,
  input wire logic                  overrun_error_flag_o
);
  wire logic rd_caps = reg_rd_i && reg_addr_i == VMR_CAPS_ADDR;
  wire logic rd_res  = reg_rd_i && reg_addr_i == VMR_RESULT_ADDR;
  wire logic rd_miss = reg_rd_i && !rd_caps && !rd_res;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  caps_word_a: assert property (
    rd_caps |=> reg_rvalid_o && reg_hit_o && reg_rdata_o == VMR_CAPS_VALUE)
    else $error("caps word wrong");
  res_rsvd_a: assert property (
    rd_res |=> reg_hit_o && reg_rdata_o[6:5] == 2'h0 && reg_rdata_o[1:0] == 2'h0)
    else $error("result reserved bits set");
  miss_read_a: assert property (
    rd_miss |=> reg_rvalid_o && !reg_hit_o && reg_rdata_o == 16'h0000)
    else $error("unmapped read answered");
  event_cause_a: assert property (
    function_event_o |-> $past(conv_done_i) && new_result_flag_o)
    else $error("event without result");
  attn_gate_a: assert property (
    attention_req_o |-> function_event_o && $past(attention_enable_i))
    else $error("attention without event or enable");
  attn_raise_a: assert property (
    function_event_o && $past(attention_enable_i) |-> attention_req_o)
    else $error("attention missing while enabled");
  sby_floor_a: assert property (
    rd_res |=> reg_rdata_o[4:2] != VMR_IDX_SBY || reg_rdata_o[15:7] >= VMR_CODE_SBY_MIN)
    else $error("standby reading below floor");
  flag_hold_a: assert property (
    new_result_flag_o && !rd_res |=> new_result_flag_o)
    else $error("new flag dropped");
  read_clear_a: assert property (
    rd_res && !conv_done_i |=> !new_result_flag_o && !overrun_error_flag_o)
    else $error("read did not clear flags");
  overrun_set_a: assert property (
    conv_done_i && new_result_flag_o && !reg_rd_i |=> overrun_error_flag_o)
    else $error("overrun not flagged");
  write_ignore_a: assert property (
    reg_wr_i && !reg_rd_i && !conv_done_i |=>
      $stable(new_result_flag_o) && $stable(overrun_error_flag_o))
    else $error("write changed flags");
  start_en_a: assert property (
    conv_start_o |-> sensor_enable_i[conv_index_o] ##1 !conv_start_o)
    else $error("start on disabled sensor");
  c_event: cover property (function_event_o);
  c_attn: cover property (attention_req_o);
  c_over: cover property (overrun_error_flag_o);
endmodule
bind vmr_top vmr_top_props #(.N_SENSORS(N_SENSORS)) u_vmr_top_props (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i),
  .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .reg_hit_o(reg_hit_o), .sensor_enable_i(sensor_enable_i),
  .attention_enable_i(attention_enable_i), .conv_start_o(conv_start_o),
  .conv_index_o(conv_index_o), .conv_done_i(conv_done_i),
  .function_event_o(function_event_o), .attention_req_o(attention_req_o),
  .new_result_flag_o(new_result_flag_o), .overrun_error_flag_o(overrun_error_flag_o));
`default_nettype wire

// ===== vmr_conv_model.sv
// Behavioural converter answering each start with one code lat_i + 1 cycles after the start is sampled.
// Assumes starts arrive only while no conversion is pending.
`timescale 1ns/1ps
`default_nettype none
module vmr_conv_model (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            start_i,
  input wire logic [2:0]      index_i,
  input wire logic [4:0][8:0] codes_i,
  input wire logic [7:0]      lat_i,
  output logic                done_o,
  output logic [8:0]          code_o
);
  logic [7:0] cnt;
  logic [2:0] idx;
  logic       busy;
  // Outside a done pulse the code is inverted so a late sample cannot match.
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      busy <= 1'b0;
      code_o <= 9'h000;
    end else if (start_i) begin
      busy <= 1'b1;
      cnt <= lat_i;
      idx <= index_i;
    end else if (busy && cnt == 8'h00) begin
      busy <= 1'b0;
      done_o <= 1'b1;
      code_o <= codes_i[idx];
    end else begin
      cnt <= cnt - 8'h01;
      code_o <= ~code_o;
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for vmr_top with a converter model.
// Inputs change at the falling edge; registers read through the strobe port.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vmr_pkg::*;
  logic clk_i, sys_rst_i = 1'b1, reg_rd_i = 1'b0, reg_wr_i = 1'b0, reg_rvalid_o, reg_hit_o;
  logic [5:0] reg_addr_i = 6'h00;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, d;
  logic [4:0] sensor_enable_i = 5'h00;
  logic attention_enable_i = 1'b0, conv_start_o, conv_done_i, function_event_o;
  logic attention_req_o, new_result_flag_o, overrun_error_flag_o;
  logic [2:0] conv_index_o;
  logic [8:0] conv_code_i;
  logic [4:0][8:0] codes = {9'h180, 9'h000, 9'h100, 9'h1ff, 9'h180};
  int n_fail = 0, checked = 0;
  vmr_top u_vmr_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_rd_i(reg_rd_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .reg_hit_o(reg_hit_o),
    .sensor_enable_i(sensor_enable_i), .attention_enable_i(attention_enable_i),
    .conv_start_o(conv_start_o), .conv_index_o(conv_index_o), .conv_done_i(conv_done_i),
    .conv_code_i(conv_code_i), .function_event_o(function_event_o),
    .attention_req_o(attention_req_o), .new_result_flag_o(new_result_flag_o),
    .overrun_error_flag_o(overrun_error_flag_o));
  vmr_conv_model u_vmr_conv_model (.clk_i(clk_i), .rst_i(sys_rst_i), .start_i(conv_start_o),
    .index_i(conv_index_o), .codes_i(codes), .lat_i(8'h14), .done_o(conv_done_i),
    .code_o(conv_code_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] wd);
    @(negedge clk_i);
    reg_rd_i = !w;
    reg_wr_i = w;
    reg_addr_i = a;
    reg_wdata_i = wd;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    reg_wr_i = 1'b0;
    chkb(reg_hit_o, a == VMR_CAPS_ADDR || a == VMR_RESULT_ADDR);
    chkb(reg_rvalid_o, !w);
    d = reg_rdata_o;
  endtask
  // Standby codes below its floor are expected lifted to the floor.
  function automatic logic [15:0] word(input logic [2:0] i);
    logic [8:0] c;
    c = (i == VMR_IDX_SBY && codes[i] < VMR_CODE_SBY_MIN) ? VMR_CODE_SBY_MIN : codes[i];
    return {c, 2'b00, i, 2'b00};
  endfunction
  task automatic wait_ev;
    int i;
    @(negedge clk_i);
    for (i = 0; i < 200 && function_event_o !== 1'b1; i++) @(negedge clk_i);
    chkb(function_event_o, 1'b1);
  endtask
  task automatic step(input logic [2:0] i);
    wait_ev;
    chkb(attention_req_o, attention_enable_i);
    chkb(new_result_flag_o, 1'b1);
    acc(1'b0, VMR_RESULT_ADDR, 16'h0000);
    chk(d, word(i));
    chkb(new_result_flag_o, 1'b0);
  endtask
  task automatic do_reset;
    sys_rst_i = 1'b1;
    repeat (8) @(negedge clk_i);
    sys_rst_i = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #(50 * 5000);
    n_fail++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    do_reset;
    acc(1'b0, VMR_CAPS_ADDR, 16'h0000);
    chk(d, 16'h0051);
    acc(1'b1, VMR_CAPS_ADDR, 16'hffff);
    acc(1'b0, VMR_CAPS_ADDR, 16'h0000);
    chk(d, 16'h0051);
    acc(1'b0, 6'h12, 16'h0000);
    chk(d, 16'h0000);
    $display("test caps done");
    sensor_enable_i = 5'h1f;
    attention_enable_i = 1'b1;
    for (int i = 0; i < 6; i++) step(3'(i % 5));
    $display("test scan_all done");
    sensor_enable_i = 5'h16;
    attention_enable_i = 1'b0;
    do_reset;
    step(3'h1);
    step(3'h2);
    step(3'h4);
    step(3'h1);
    wait_ev;
    wait_ev;
    chkb(overrun_error_flag_o, 1'b1);
    acc(1'b1, VMR_RESULT_ADDR, 16'hffff);
    chkb(overrun_error_flag_o, 1'b1);
    chkb(new_result_flag_o, 1'b1);
    acc(1'b0, VMR_RESULT_ADDR, 16'h0000);
    chk(d, word(3'h4));
    chkb(overrun_error_flag_o, 1'b0);
    $display("test skip_overrun done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
